// ### hdl/agc_path_consts.svh
// Purpose: Offsets, field positions, reset values and decay constants of the decay/ADC path bank.
// Assumes: Byte-wide registers on a plain strobe port.
// Notes: Times are kept in milliseconds.
`ifndef AGC_PATH_CONSTS_SVH
`define AGC_PATH_CONSTS_SVH

`define OFS_RIGHT_GAIN_DECAY_TIME 7'h6a
`define OFS_ADC_PATH_AND_BUS_ERROR 7'h6b
`define OFS_PAGE_SELECT 7'h00
`define RST_RIGHT_GAIN_DECAY_TIME 8'h00
`define RST_ADC_PATH_AND_BUS_ERROR 8'h00
`define RST_PAGE_SELECT 1'b0

`define DECAY_SRC_BIT 7
`define DECAY_BASE_HI 6
`define DECAY_BASE_LO 5
`define DECAY_MULT_HI 4
`define DECAY_MULT_LO 2
`define PATH_HPF_LEFT_BIT 7
`define PATH_HPF_RIGHT_BIT 6
`define PATH_DECIM_HI 5
`define PATH_DECIM_LO 4
`define PATH_PROG_FILT_BIT 3
`define PATH_BUSERR_DIS_BIT 2
`define PATH_BUSERR_STAT_BIT 0
`define PATH_WRITE_MASK 8'hfc

`define DECAY_BASE0_MS 24'h000032
`define DECAY_BASE1_MS 24'h000096
`define DECAY_BASE2_MS 24'h0000fa
`define DECAY_BASE3_MS 24'h00015e

`define DECAY_CAP_1_MS 24'h000fa0
`define DECAY_CAP_1P5_MS 24'h0015e0
`define DECAY_CAP_2_MS 24'h001f40
`define DECAY_CAP_2P5_MS 24'h002580
`define DECAY_CAP_3_MS 24'h002bc0
`define DECAY_CAP_4_MS 24'h003e80
`define DECAY_CAP_5_MS 24'h004b00
`define DECAY_CAP_5P5_MS 24'h005780

`endif

// ### hdl/agc_path_pkg.sv
// Purpose: Types shared by the decay/ADC path bank.
// Assumes: Nothing beyond the constants header.
// Notes: Divide ratio is coded in half steps, code n meaning ratio (n+2)/2.
package agc_path_pkg;
    typedef logic [23:0] decay_ms_t;
    typedef logic [3:0] adc_clock_divide_ratio_t;
    typedef enum logic [3:0] {
        MIC_DIG_DIG = 4'h1,
        MIC_DIG_ANA = 4'h2,
        MIC_ANA_DIG = 4'h4,
        MIC_ANA_ANA = 4'h8
    } mic_mode_t;
endpackage

// ### hdl/agc_decay_adc_path_config.sv
// Purpose: Right gain-loop decay register and ADC digital path / bus error register.
// Assumes: Host strobes are synchronous and one cycle long; read data appear one cycle later.
// Notes: Registers sit on page 0; page select lives at offset 0 and is visible on both pages.
// Overview of operation
// - Decay source bit 7 picks older timing register 29 or this register's fields.
// - Bits 6-5 give baseline decay of 50, 150, 250 or 350 ms.
// - Bits 4-2 multiply baseline by two to the code, 1 to 128.
// - Decay is capped by divide ratio, 4 s at 1 up to 22.4 s.
// - Bit 7 picks default or programmable high-pass coefficients, left channel.
// - Bit 6 picks default or programmable high-pass coefficients, right channel.
// - Bits 5-4 pick digital or analog microphone per channel for decimation.
// - Bit 3 connects programmable filter to ADC output only with both DACs down.
// - Bit 2 low enables bus error detection and clearing; high disables it.
// - Status bit 0 shows a detected bus error; reading the register clears it.
// - Page select bit 0 chooses the active page; these registers live in page 0.
`include "agc_path_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module agc_decay_adc_path_config (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    // Register port.
    input wire logic [6:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic write_i,
    input wire logic read_i,
    output logic [7:0] rdata_o,
    // Codec context.
    input wire logic [3:0] adc_clock_divide_ratio_i,
    input wire logic [23:0] legacy_decay_ms_i,
    input wire logic adc_highpass_filter_en_i,
    input wire logic dacs_powered_down_i,
    input wire logic bus_error_event_i,
    // Path controls.
    output logic [23:0] right_decay_ms_o,
    output logic hpf_left_prog_coef_o,
    output logic hpf_right_prog_coef_o,
    output logic left_mic_analog_o,
    output logic right_mic_analog_o,
    output logic prog_filter_on_adc_o,
    output logic bus_error_detect_en_o,
    output logic bus_error_clear_o,
    output logic page_sel_o
);

    // =====================================================================
    // Register state.
    // =====================================================================
    logic [7:0] decay_reg_r;
    logic [7:0] decay_reg_nxt;
    logic [7:0] path_reg_r;
    logic [7:0] path_reg_nxt;
    logic bus_err_r;
    logic bus_err_nxt;
    logic page_r;
    logic page_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic on_page0;
    logic hit_decay;
    logic hit_path;
    logic hit_page;

    // =====================================================================
    // Address decode.
    // =====================================================================
    always_comb begin
        on_page0 = (page_r == 1'b0);
        hit_decay = on_page0 && (addr_i == `OFS_RIGHT_GAIN_DECAY_TIME);
        hit_path = on_page0 && (addr_i == `OFS_ADC_PATH_AND_BUS_ERROR);
        hit_page = (addr_i == `OFS_PAGE_SELECT);
    end

    // =====================================================================
    // Right decay register.
    // =====================================================================
    always_comb begin
        decay_reg_nxt = decay_reg_r;
        // Reserved low bits are kept as written; host is expected to write zeros.
        if (write_i && hit_decay) begin
            decay_reg_nxt = wdata_i;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            decay_reg_r <= `RST_RIGHT_GAIN_DECAY_TIME;
        end else if (clk_en_i) begin
            decay_reg_r <= decay_reg_nxt;
        end
    end

    // =====================================================================
    // ADC path register.
    // =====================================================================
    always_comb begin
        path_reg_nxt = path_reg_r;
        // Bits 1 and 0 are not writable; the status bit is held apart.
        if (write_i && hit_path) begin
            path_reg_nxt = wdata_i & `PATH_WRITE_MASK;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            path_reg_r <= `RST_ADC_PATH_AND_BUS_ERROR;
        end else if (clk_en_i) begin
            path_reg_r <= path_reg_nxt;
        end
    end

    // =====================================================================
    // Page select.
    // =====================================================================
    always_comb begin
        page_nxt = page_r;
        if (write_i && hit_page) begin
            page_nxt = wdata_i[0];
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            page_r <= `RST_PAGE_SELECT;
        end else if (clk_en_i) begin
            page_r <= page_nxt;
        end
    end

    // =====================================================================
    // Bus error status.
    // =====================================================================
    always_comb begin
        bus_err_nxt = bus_err_r;
        if (read_i && hit_path) begin
            bus_err_nxt = 1'b0;
        end
        // A new error in the cycle of the clearing read is kept.
        if (bus_error_event_i && !path_reg_r[`PATH_BUSERR_DIS_BIT]) begin
            bus_err_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            bus_err_r <= 1'b0;
        end else if (clk_en_i) begin
            bus_err_r <= bus_err_nxt;
        end
    end

    // =====================================================================
    // Read data.
    // =====================================================================
    always_comb begin
        rdata_nxt = 8'h00;
        if (read_i) begin
            if (hit_decay) begin
                rdata_nxt = decay_reg_r;
            end else if (hit_path) begin
                rdata_nxt = path_reg_r;
                rdata_nxt[`PATH_BUSERR_STAT_BIT] = bus_err_r;
            end else if (hit_page) begin
                rdata_nxt = {7'h00, page_r};
            end
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            rdata_r <= 8'h00;
        end else if (clk_en_i) begin
            rdata_r <= rdata_nxt;
        end
    end

    // =====================================================================
    // Decay time computation.
    // =====================================================================
    agc_path_pkg::decay_ms_t base_ms;
    agc_path_pkg::decay_ms_t cap_ms;
    logic [31:0] scaled_ms;
    agc_path_pkg::decay_ms_t own_ms;
    agc_path_pkg::decay_ms_t decay_nxt;
    agc_path_pkg::decay_ms_t decay_r;

    always_comb begin
        case (decay_reg_r[`DECAY_BASE_HI:`DECAY_BASE_LO])
            2'h0: base_ms = `DECAY_BASE0_MS;
            2'h1: base_ms = `DECAY_BASE1_MS;
            2'h2: base_ms = `DECAY_BASE2_MS;
            default: base_ms = `DECAY_BASE3_MS;
        endcase
    end

    // =====================================================================
    // Decay ceiling.
    // =====================================================================
    // Ratio code n stands for divide ratio (n+2)/2; codes 9 and up keep the top ceiling.
    always_comb begin
        case (adc_clock_divide_ratio_i)
            4'h0: cap_ms = `DECAY_CAP_1_MS;
            4'h1: cap_ms = `DECAY_CAP_1P5_MS;
            4'h2: cap_ms = `DECAY_CAP_2_MS;
            4'h3: cap_ms = `DECAY_CAP_2P5_MS;
            4'h4: cap_ms = `DECAY_CAP_3_MS;
            4'h5: cap_ms = `DECAY_CAP_3_MS;
            4'h6: cap_ms = `DECAY_CAP_4_MS;
            4'h7: cap_ms = `DECAY_CAP_4_MS;
            4'h8: cap_ms = `DECAY_CAP_5_MS;
            4'h9: cap_ms = `DECAY_CAP_5P5_MS;
            4'ha: cap_ms = `DECAY_CAP_5P5_MS;
            default: cap_ms = `DECAY_CAP_5P5_MS;
        endcase
    end

    always_comb begin
        scaled_ms = {8'h00, base_ms} << decay_reg_r[`DECAY_MULT_HI:`DECAY_MULT_LO];
        if (scaled_ms > {8'h00, cap_ms}) begin
            own_ms = cap_ms;
        end else begin
            own_ms = scaled_ms[23:0];
        end
    end

    // =====================================================================
    // Decay source select.
    // =====================================================================
    always_comb begin
        if (decay_reg_r[`DECAY_SRC_BIT]) begin
            decay_nxt = own_ms;
        end else begin
            decay_nxt = legacy_decay_ms_i;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            decay_r <= 24'h000000;
        end else if (clk_en_i) begin
            decay_r <= decay_nxt;
        end
    end

    // =====================================================================
    // ADC path controls.
    // =====================================================================
    agc_path_pkg::mic_mode_t mic_mode;
    logic hpf_left_r;
    logic hpf_left_nxt;
    logic hpf_right_r;
    logic hpf_right_nxt;
    logic left_mic_r;
    logic left_mic_nxt;
    logic right_mic_r;
    logic right_mic_nxt;
    logic prog_filt_r;
    logic prog_filt_nxt;
    logic detect_en_r;
    logic detect_en_nxt;
    logic err_clear_r;
    logic err_clear_nxt;

    always_comb begin
        case (path_reg_r[`PATH_DECIM_HI:`PATH_DECIM_LO])
            2'h0: mic_mode = agc_path_pkg::MIC_DIG_DIG;
            2'h1: mic_mode = agc_path_pkg::MIC_DIG_ANA;
            2'h2: mic_mode = agc_path_pkg::MIC_ANA_DIG;
            default: mic_mode = agc_path_pkg::MIC_ANA_ANA;
        endcase
        case (mic_mode)
            agc_path_pkg::MIC_DIG_DIG: begin
                left_mic_nxt = 1'b0;
                right_mic_nxt = 1'b0;
            end
            agc_path_pkg::MIC_DIG_ANA: begin
                left_mic_nxt = 1'b0;
                right_mic_nxt = 1'b1;
            end
            agc_path_pkg::MIC_ANA_DIG: begin
                left_mic_nxt = 1'b1;
                right_mic_nxt = 1'b0;
            end
            agc_path_pkg::MIC_ANA_ANA: begin
                left_mic_nxt = 1'b1;
                right_mic_nxt = 1'b1;
            end
            default: begin
                left_mic_nxt = 1'b0;
                right_mic_nxt = 1'b0;
            end
        endcase
    end

    // =====================================================================
    // Path control flags.
    // =====================================================================
    always_comb begin
        hpf_left_nxt = adc_highpass_filter_en_i && path_reg_r[`PATH_HPF_LEFT_BIT];
        hpf_right_nxt = adc_highpass_filter_en_i && path_reg_r[`PATH_HPF_RIGHT_BIT];
        prog_filt_nxt = path_reg_r[`PATH_PROG_FILT_BIT] && dacs_powered_down_i;
        detect_en_nxt = !path_reg_r[`PATH_BUSERR_DIS_BIT];
        err_clear_nxt = bus_error_event_i && !path_reg_r[`PATH_BUSERR_DIS_BIT];
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            hpf_left_r <= 1'b0;
            hpf_right_r <= 1'b0;
            left_mic_r <= 1'b0;
            right_mic_r <= 1'b0;
            prog_filt_r <= 1'b0;
            detect_en_r <= 1'b1;
            err_clear_r <= 1'b0;
        end else if (clk_en_i) begin
            hpf_left_r <= hpf_left_nxt;
            hpf_right_r <= hpf_right_nxt;
            left_mic_r <= left_mic_nxt;
            right_mic_r <= right_mic_nxt;
            prog_filt_r <= prog_filt_nxt;
            detect_en_r <= detect_en_nxt;
            err_clear_r <= err_clear_nxt;
        end
    end

    // =====================================================================
    // Output ports.
    // =====================================================================
    assign rdata_o = rdata_r;
    assign right_decay_ms_o = decay_r;
    assign hpf_left_prog_coef_o = hpf_left_r;
    assign hpf_right_prog_coef_o = hpf_right_r;
    assign left_mic_analog_o = left_mic_r;
    assign right_mic_analog_o = right_mic_r;
    assign prog_filter_on_adc_o = prog_filt_r;
    assign bus_error_detect_en_o = detect_en_r;
    assign bus_error_clear_o = err_clear_r;
    assign page_sel_o = page_r;

endmodule

`default_nettype wire

// ### dv/agc_path_chk_assertions.sv
// Purpose: Port checker for the decay and ADC path bank.
// Assumes: Clock enable held high.
// Notes: Bound to every bank instance.
`timescale 1ns/1ps
`default_nettype none
module agc_path_chk (
    // Watched ports.
    input wire logic clk_i, reset_i, write_i, read_i, bus_error_event_i,
    input wire logic [6:0] addr_i,
    input wire logic [7:0] wdata_i, rdata_o,
    input wire logic adc_highpass_filter_en_i, dacs_powered_down_i, page_sel_o, left_mic_analog_o,
    input wire logic hpf_left_prog_coef_o, hpf_right_prog_coef_o, prog_filter_on_adc_o,
    input wire logic bus_error_detect_en_o, bus_error_clear_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    sequence rd_s; read_i && addr_i == 7'h6b && !bus_error_event_i; endsequence
    clear_on_a: assert property (bus_error_event_i && bus_error_detect_en_o |=> bus_error_clear_o)
        else $error("clear missing");
    clear_off_a: assert property (!(bus_error_event_i && bus_error_detect_en_o) |=> !bus_error_clear_o)
        else $error("clear unexpected");
    filter_gate_a: assert property (prog_filter_on_adc_o |-> $past(dacs_powered_down_i))
        else $error("filter on with dacs up");
    hpf_left_a: assert property (hpf_left_prog_coef_o |-> $past(adc_highpass_filter_en_i))
        else $error("left coef without filter");
    hpf_right_a: assert property (hpf_right_prog_coef_o |-> $past(adc_highpass_filter_en_i))
        else $error("right coef without filter");
    page_read_a: assert property (read_i && addr_i == 7'h00 |=> rdata_o == {7'h00, page_sel_o})
        else $error("page readback");
    status_clear_a: assert property (rd_s ##1 !bus_error_event_i ##1 rd_s |=> rdata_o[1:0] == 2'b00)
        else $error("status not cleared");
    mic_sel_a: assert property (write_i && addr_i == 7'h6b && !page_sel_o ##1 !write_i
        |=> left_mic_analog_o == $past(wdata_i[5], 2)) else $error("mic select");
    cover property (bus_error_clear_o);
    cover property (prog_filter_on_adc_o);
    cover property ($rose(page_sel_o));
endmodule
bind agc_decay_adc_path_config agc_path_chk u_chk (
    .clk_i(clk_i), .reset_i(reset_i), .write_i(write_i), .read_i(read_i),
    .bus_error_event_i(bus_error_event_i), .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
    .adc_highpass_filter_en_i(adc_highpass_filter_en_i), .dacs_powered_down_i(dacs_powered_down_i),
    .page_sel_o(page_sel_o), .left_mic_analog_o(left_mic_analog_o),
    .hpf_left_prog_coef_o(hpf_left_prog_coef_o), .hpf_right_prog_coef_o(hpf_right_prog_coef_o),
    .prog_filter_on_adc_o(prog_filter_on_adc_o), .bus_error_detect_en_o(bus_error_detect_en_o),
    .bus_error_clear_o(bus_error_clear_o));
`default_nettype wire

// ### dv/host_bus_model.sv
// Purpose: Host on the register port.
// Assumes: One transfer at a time.
// Notes: Write data toggles once released.
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
    // Bus.
    input wire logic clk_i,
    input wire logic [7:0] rdata_i,
    output logic [6:0] addr_o = 7'h00,
    output logic [7:0] wdata_o = 8'h00,
    output logic write_o = 1'b0,
    output logic read_o = 1'b0
);
    task automatic xfer(input logic w, input logic [6:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= (a == 7'h6a) ? (d & 8'hfc) : d;
        write_o <= w;
        read_o <= !w;
        @(posedge clk_i);
        write_o <= 1'b0;
        read_o <= 1'b0;
        wdata_o <= ~wdata_o;
        #1 q = rdata_i;
    endtask
endmodule
`default_nettype wire

// ### dv/agc_decay_adc_path_config_tb_top.sv
// Purpose: Self-checking bench for the decay and ADC path bank.
// Assumes: Clock enable held high except during one frozen write.
// Notes: Host traffic goes through the bus model.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin miscompares++; \
    $display("wrong value %s exp %0h got %0h", n, e, s); end end
module agc_decay_adc_path_config_tb_top;
    logic clk_i = 1'b0, reset_i = 1'b1, clk_en_i = 1'b1, adc_highpass_filter_en_i = 1'b0;
    logic dacs_powered_down_i = 1'b0, bus_error_event_i = 1'b0, write_i, read_i;
    logic [3:0] adc_clock_divide_ratio_i = 4'h0;
    logic [23:0] legacy_decay_ms_i = 24'h000123, right_decay_ms_o, e;
    logic [6:0] addr_i;
    logic [7:0] wdata_i, rdata_o, q, v;
    logic hpf_left_prog_coef_o, hpf_right_prog_coef_o, left_mic_analog_o, right_mic_analog_o;
    logic prog_filter_on_adc_o, bus_error_detect_en_o, bus_error_clear_o, page_sel_o;
    logic [23:0] cap [11] = '{24'h0fa0, 24'h15e0, 24'h1f40, 24'h2580, 24'h2bc0, 24'h2bc0,
        24'h3e80, 24'h3e80, 24'h4b00, 24'h5780, 24'h5780};
    int miscompares = 0, samples_checked = 0, cyc = 0;
    agc_decay_adc_path_config DUT (
        .clk_i(clk_i), .reset_i(reset_i), .clk_en_i(clk_en_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .write_i(write_i), .read_i(read_i), .rdata_o(rdata_o),
        .adc_clock_divide_ratio_i(adc_clock_divide_ratio_i), .legacy_decay_ms_i(legacy_decay_ms_i),
        .adc_highpass_filter_en_i(adc_highpass_filter_en_i), .dacs_powered_down_i(dacs_powered_down_i),
        .bus_error_event_i(bus_error_event_i), .right_decay_ms_o(right_decay_ms_o),
        .hpf_left_prog_coef_o(hpf_left_prog_coef_o), .hpf_right_prog_coef_o(hpf_right_prog_coef_o),
        .left_mic_analog_o(left_mic_analog_o), .right_mic_analog_o(right_mic_analog_o),
        .prog_filter_on_adc_o(prog_filter_on_adc_o), .bus_error_detect_en_o(bus_error_detect_en_o),
        .bus_error_clear_o(bus_error_clear_o), .page_sel_o(page_sel_o));
    host_bus_model bus (.clk_i, .rdata_i(rdata_o), .addr_o(addr_i), .wdata_o(wdata_i), .write_o(write_i),
        .read_o(read_i));
    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            final_report();
        end
    end
    task automatic idle(int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask
    task automatic t_decay();
        for (int n = 0; n < 11; n++) begin
            adc_clock_divide_ratio_i <= n[3:0];
            for (int b = 0; b < 4; b++) begin
                for (int m = 0; m < 8; m++) begin
                    e = 24'((24'h000032 + 24'h000064 * b) << m);
                    if (e > cap[n]) e = cap[n];
                    bus.xfer(1'b1, 7'h6a, {1'b1, b[1:0], m[2:0], 2'b00}, q);
                    idle(2);
                    `CHK("decay", e, right_decay_ms_o)
                end
            end
        end
    endtask
    task automatic t_path();
        for (int i = 0; i < 64; i++) begin
            v = {i[5:0], 2'b11};
            adc_highpass_filter_en_i <= i[2];
            dacs_powered_down_i <= i[0];
            bus.xfer(1'b1, 7'h6b, v, q);
            idle(2);
            `CHK("hpf", {v[7] & i[2], v[6] & i[2]}, {hpf_left_prog_coef_o, hpf_right_prog_coef_o})
            `CHK("mic", v[5:4], {left_mic_analog_o, right_mic_analog_o})
            `CHK("filter", v[3] & i[0], prog_filter_on_adc_o)
            `CHK("detect", ~v[2], bus_error_detect_en_o)
            bus.xfer(1'b0, 7'h6b, 8'h00, q);
            `CHK("path reg", {v[7:2], 2'b00}, q)
        end
    endtask
    task automatic t_err(input logic [7:0] cfg, input logic x);
        bus.xfer(1'b1, 7'h6b, cfg, q);
        idle(2);
        bus_error_event_i <= 1'b1;
        idle(1);
        bus_error_event_i <= 1'b0;
        `CHK("clear", x, bus_error_clear_o)
        bus.xfer(1'b0, 7'h6b, 8'h00, q);
        `CHK("status", {cfg[7:2], 1'b0, x}, q)
        bus.xfer(1'b0, 7'h6b, 8'h00, q);
        `CHK("status again", {cfg[7:2], 2'b00}, q)
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk_i);
        reset_i <= 1'b0;
        idle(2);
        `CHK("legacy", legacy_decay_ms_i, right_decay_ms_o)
        bus.xfer(1'b0, 7'h6a, 8'h00, q);
        `CHK("decay reset", 8'h00, q)
        t_decay();
        bus.xfer(1'b1, 7'h6a, 8'h7c, q);
        idle(2);
        `CHK("legacy again", legacy_decay_ms_i, right_decay_ms_o)
        clk_en_i <= 1'b0;
        bus.xfer(1'b1, 7'h6a, 8'hfc, q);
        idle(2);
        clk_en_i <= 1'b1;
        bus.xfer(1'b0, 7'h6a, 8'h00, q);
        `CHK("frozen", 8'h7c, q)
        t_path();
        t_err(8'h00, 1'b1);
        t_err(8'h04, 1'b0);
        bus.xfer(1'b1, 7'h00, 8'h01, q);
        bus.xfer(1'b0, 7'h6b, 8'h00, q);
        `CHK("page one", 8'h00, q)
        bus.xfer(1'b0, 7'h00, 8'h00, q);
        `CHK("page sel", 8'h01, q)
        bus.xfer(1'b1, 7'h00, 8'h00, q);
        bus.xfer(1'b0, 7'h50, 8'h00, q);
        `CHK("unmapped", 8'h00, q)
        final_report();
    end
endmodule
`default_nettype wire
